/* src/aux_ctrl_pkg.sv */
// Purpose : Constants and carriers for the auxiliary control register bank
// Assumes : APB with 32-bit data, registers at their printed offsets
// Notes   : Printed offsets step by one, not by four, so byte address is index times four
package aux_ctrl_pkg;

  // ---------------------------------------------------------------
  // Register indices and byte addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_PORT  = 8'h14;
  localparam logic [7:0] IDX_TAP   = 8'h15;
  localparam logic [7:0] IDX_BRTH  = 8'h16;
  localparam logic [7:0] IDX_CFG4  = 8'h17;
  localparam logic [9:0] ADDR_PORT = {IDX_PORT, 2'b00};
  localparam logic [9:0] ADDR_TAP  = {IDX_TAP, 2'b00};
  localparam logic [9:0] ADDR_BRTH = {IDX_BRTH, 2'b00};
  localparam logic [9:0] ADDR_CFG4 = {IDX_CFG4, 2'b00};

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_PORT = 8'h0F;
  localparam logic [7:0] RST_TAP  = 8'h00;
  localparam logic [7:0] RST_BRTH = 8'h00;
  localparam logic [7:0] RST_CFG4 = 8'h00;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int PIN_DATA_LSB  = 4;
  localparam int PIN_DIR_LSB   = 0;
  localparam int EVEN_TAP_LSB  = 3;
  localparam int ODD_TAP_LSB   = 1;
  localparam int TAP_BUF_BIT   = 0;
  localparam int DEMOD_BIT     = 7;
  localparam int MOD_BIT       = 6;
  localparam int PHASE_LSB     = 2;
  localparam int MODE_LSB      = 0;
  localparam int FREQ_LSB      = 5;
  localparam int SHOT_BIT      = 3;
  localparam int TERM_BIT      = 2;
  localparam int COMP_BIT      = 1;
  localparam logic [7:0] CFG4_WMASK = 8'hEE;
  localparam logic [7:0] TAP_WMASK  = 8'h1F;

  // ---------------------------------------------------------------
  // Codes and timing
  // ---------------------------------------------------------------
  localparam logic [1:0] MODE_EXT      = 2'h1;
  localparam logic [1:0] MODE_INT      = 2'h2;
  localparam logic [1:0] MODE_INT_USER = 2'h3;
  localparam logic [2:0] PHASE_BAD     = 3'h7;
  localparam logic [2:0] FREQ_SQ_MIN   = 3'h2;
  localparam int         CLK_HZ        = 100_000_000;
  localparam int         SQ16K_HZ      = 16_000;
  // Half period of the 16 kHz square wave; slower codes double it per step
  localparam int         SQ_HALF_CYC   = CLK_HZ / (2 * SQ16K_HZ);
  // Wide enough for the slowest code, whose half period exceeds 16 bits
  localparam int         SQ_CNT_W      = 17;

  typedef struct packed {
    logic [2:0] freq;
    logic       single_shot;
    logic       terminal_to_drive_link;
    logic       detach_comparator_enable;
  } cfg4_t;

  typedef struct packed {
    logic       breath_demod_enable;
    logic       breath_mod_enable;
    logic [2:0] breath_phase;
    logic       phase_active;
    logic [1:0] breath_mode;
  } breath_t;

  typedef struct packed {
    logic [1:0] even_tap_select;
    logic [1:0] odd_tap_select;
    logic       tap_buffer_on;
  } tap_t;

endpackage

/* src/pin_sync.sv */
// Purpose : Two-stage synchroniser for the four port pins
// Assumes : Pins are asynchronous to sys_clk_i
// Notes   : First stage feeds only the second stage
`timescale 1ns/100ps
`default_nettype none
module pin_sync
(
  input  wire logic       sys_clk_i,
  input  wire logic       nrst_i,
  input  wire logic [3:0] pin_i,
  output logic      [3:0] pin_o
);

  logic [3:0] meta_ff;
  logic [3:0] sync_ff;

  always_ff @(posedge sys_clk_i)
  begin
    if (!nrst_i)
    begin
      meta_ff <= 4'h0;
      sync_ff <= 4'h0;
    end
    else
    begin
      meta_ff <= pin_i;
      sync_ff <= meta_ff;
    end
  end

  assign pin_o = sync_ff;

endmodule
`default_nettype wire

/* src/square_gen.sv */
// Purpose : Single square wave for the breathing frequency codes 010 to 111; aux_ctrl_regs inverts it for pin four
// Assumes : 100 MHz clock
// Notes   : Half period is the 16 kHz half period shifted left by code minus two
`timescale 1ns/100ps
`default_nettype none
module square_gen
(
  input  wire logic       sys_clk_i,
  input  wire logic       nrst_i,
  input  wire logic [2:0] freq_i,
  output logic            wave_o
);

  logic [aux_ctrl_pkg::SQ_CNT_W-1:0] cnt_ff;
  logic [aux_ctrl_pkg::SQ_CNT_W-1:0] nxt_cnt;
  logic [aux_ctrl_pkg::SQ_CNT_W-1:0] half;
  logic                              wave_ff;
  logic                              nxt_wave;
  logic [2:0]                        shift;

  always_comb
  begin
    shift    = freq_i - aux_ctrl_pkg::FREQ_SQ_MIN;
    half     = aux_ctrl_pkg::SQ_CNT_W'(aux_ctrl_pkg::SQ_HALF_CYC) << shift;
    nxt_cnt  = cnt_ff + 1'b1;
    nxt_wave = wave_ff;
    // Modulation codes hold the wave still so the pins do not toggle
    if (freq_i < aux_ctrl_pkg::FREQ_SQ_MIN)
    begin
      nxt_cnt  = '0;
      nxt_wave = 1'b0;
    end
    else if (nxt_cnt >= half)
    begin
      nxt_cnt  = '0;
      nxt_wave = ~wave_ff;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!nrst_i)
    begin
      cnt_ff  <= '0;
      wave_ff <= 1'b0;
    end
    else
    begin
      cnt_ff  <= nxt_cnt;
      wave_ff <= nxt_wave;
    end
  end

  assign wave_o = wave_ff;

endmodule
`default_nettype wire

/* src/aux_ctrl_regs.sv */
// Purpose : APB register bank for port, tap select, breathing and fourth config registers
// Assumes : APB slave with one registered wait state; pins synchronised before use
// Notes   : Decoded outputs lag a register write by one cycle
`timescale 1ns/100ps
`default_nettype none
module aux_ctrl_regs
(
  input  wire logic                  sys_clk_i,
  input  wire logic                  nrst_i,
  input  wire logic                  psel_i,
  input  wire logic                  penable_i,
  input  wire logic                  pwrite_i,
  input  wire logic [11:0]           paddr_i,
  input  wire logic [31:0]           pwdata_i,
  input  wire logic [3:0]            pstrb_i,
  output logic      [31:0]           prdata_o,
  output logic                       pready_o,
  output logic                       pslverr_o,
  input  wire logic [3:0]            port_pin_i,
  output logic      [3:0]            port_pin_o,
  output logic      [3:0]            port_pin_oe_o,
  output aux_ctrl_pkg::tap_t         tap_o,
  output logic      [7:0]            first_tap_output_o,
  output logic      [7:0]            second_tap_output_o,
  output aux_ctrl_pkg::breath_t      breath_o,
  output aux_ctrl_pkg::cfg4_t        cfg4_o
);

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [3:0]  pin_dir_field_ff;
  logic [3:0]  pin_data_out_ff;
  logic [7:0]  tap_ff;
  logic [7:0]  breath_ff;
  logic [7:0]  cfg4_ff;
  logic [31:0] rdata_ff;
  logic        ready_ff;
  logic        err_ff;
  logic [3:0]  pin_out_ff;
  logic [3:0]  pin_oe_ff;
  logic [7:0]  first_tap_ff;
  logic [7:0]  second_tap_ff;
  aux_ctrl_pkg::tap_t    tap_q_ff;
  aux_ctrl_pkg::breath_t breath_q_ff;
  aux_ctrl_pkg::cfg4_t   cfg4_q_ff;

  logic [3:0]  nxt_pin_dir;
  logic [3:0]  nxt_pin_data;
  logic [7:0]  nxt_tap;
  logic [7:0]  nxt_breath;
  logic [7:0]  nxt_cfg4;
  logic [31:0] nxt_rdata;
  logic        nxt_ready;
  logic        nxt_err;
  logic [3:0]  nxt_pin_out;
  logic [3:0]  nxt_pin_oe;
  logic [7:0]  nxt_first_tap;
  logic [7:0]  nxt_second_tap;
  aux_ctrl_pkg::tap_t    nxt_tap_q;
  aux_ctrl_pkg::breath_t nxt_breath_q;
  aux_ctrl_pkg::cfg4_t   nxt_cfg4_q;

  logic [3:0] pin_sync;
  logic       sq_wave;
  logic       access;
  logic       hit;
  logic       lane0;
  logic [7:0] wbyte;
  logic [3:0] port_taken;
  logic [1:0] mode;
  logic [2:0] freq;
  logic [9:0] word;

  // ---------------------------------------------------------------
  // Word indices and masks
  // ---------------------------------------------------------------
  // Word index is the byte address over four
  localparam logic [9:0] WORD_PORT  = {2'b00, aux_ctrl_pkg::IDX_PORT};
  localparam logic [9:0] WORD_TAP   = {2'b00, aux_ctrl_pkg::IDX_TAP};
  localparam logic [9:0] WORD_BRTH  = {2'b00, aux_ctrl_pkg::IDX_BRTH};
  localparam logic [9:0] WORD_CFG4  = {2'b00, aux_ctrl_pkg::IDX_CFG4};
  localparam logic [3:0] TAKEN_MASK = 4'hE;

  // ---------------------------------------------------------------
  // Submodules
  // ---------------------------------------------------------------
  // Pins cross into the clock domain through two flops
  pin_sync u_pin_sync
  (
    .sys_clk_i (sys_clk_i),
    .nrst_i    (nrst_i),
    .pin_i     (port_pin_i),
    .pin_o     (pin_sync)
  );

  square_gen u_square_gen
  (
    .sys_clk_i (sys_clk_i),
    .nrst_i    (nrst_i),
    .freq_i    (freq),
    .wave_o    (sq_wave)
  );

  // ---------------------------------------------------------------
  // Bus decode and register update
  // ---------------------------------------------------------------
  assign mode   = breath_ff[aux_ctrl_pkg::MODE_LSB +: 2];
  assign freq   = cfg4_ff[aux_ctrl_pkg::FREQ_LSB +: 3];
  assign lane0  = pstrb_i[0];
  assign wbyte  = pwdata_i[7:0];
  assign word   = paddr_i[11:2];
  // Access is taken in its first cycle; pready is registered so a
  // transfer always takes setup plus two access cycles
  assign access = psel_i && penable_i && !ready_ff;
  // Address bits 1:0 are ignored; bits 11:10 must be zero for a hit
  assign hit    = (word == WORD_PORT) || (word == WORD_TAP) || (word == WORD_BRTH) || (word == WORD_CFG4);

  always_comb
  begin
    nxt_pin_dir  = pin_dir_field_ff;
    nxt_pin_data = pin_data_out_ff;
    nxt_tap      = tap_ff;
    nxt_breath   = breath_ff;
    nxt_cfg4     = cfg4_ff;
    nxt_rdata    = rdata_ff;
    nxt_ready    = access;
    nxt_err      = access && !hit;
    // Only byte lane zero carries register data
    if (access && pwrite_i && lane0)
    begin
      unique case (word)
        WORD_PORT:
        begin
          nxt_pin_dir = wbyte[aux_ctrl_pkg::PIN_DIR_LSB +: 4];
          // Latch stores the level; only output pins see it on the pad
          nxt_pin_data = wbyte[aux_ctrl_pkg::PIN_DATA_LSB +: 4];
        end
        // Reserved bits of the tap and fourth registers are stored as zero
        WORD_TAP:  nxt_tap    = wbyte & aux_ctrl_pkg::TAP_WMASK;
        WORD_BRTH: nxt_breath = wbyte;
        WORD_CFG4: nxt_cfg4   = wbyte & aux_ctrl_pkg::CFG4_WMASK;
        default: ;
      endcase
    end
    // Unmapped reads return zero alongside the error response
    if (access && !pwrite_i)
    begin
      unique case (word)
        WORD_PORT: nxt_rdata = {24'h000000, pin_sync, pin_dir_field_ff};
        WORD_TAP:  nxt_rdata = {24'h000000, tap_ff};
        WORD_BRTH: nxt_rdata = {24'h000000, breath_ff};
        WORD_CFG4: nxt_rdata = {24'h000000, cfg4_ff};
        default:   nxt_rdata = 32'h00000000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Pin drive
  // ---------------------------------------------------------------
  always_comb
  begin
    port_taken = 4'h0;
    // Modes 01 and 11 own pins two to four
    if (mode == aux_ctrl_pkg::MODE_EXT || mode == aux_ctrl_pkg::MODE_INT_USER)
    begin
      port_taken = TAKEN_MASK;
    end
    nxt_pin_oe  = ~pin_dir_field_ff & ~port_taken;
    nxt_pin_out = pin_data_out_ff & ~port_taken;
    // Square wave on pins three and four, pin four inverted
    if (freq >= aux_ctrl_pkg::FREQ_SQ_MIN)
    begin
      nxt_pin_oe[2]  = 1'b1;
      nxt_pin_oe[3]  = 1'b1;
      nxt_pin_out[2] = sq_wave;
      nxt_pin_out[3] = ~sq_wave;
    end
  end

  // ---------------------------------------------------------------
  // Decoded control outputs
  // ---------------------------------------------------------------
  always_comb
  begin
    nxt_tap_q.even_tap_select = tap_ff[aux_ctrl_pkg::EVEN_TAP_LSB +: 2];
    nxt_tap_q.odd_tap_select  = tap_ff[aux_ctrl_pkg::ODD_TAP_LSB +: 2];
    nxt_tap_q.tap_buffer_on   = tap_ff[aux_ctrl_pkg::TAP_BUF_BIT];
    // One-hot channel route; code n picks even channel 2n+2, odd 2n+1
    nxt_first_tap  = 8'h02 << {nxt_tap_q.even_tap_select, 1'b0};
    nxt_second_tap = 8'h01 << {nxt_tap_q.odd_tap_select, 1'b0};
    nxt_breath_q.breath_demod_enable = breath_ff[aux_ctrl_pkg::DEMOD_BIT];
    nxt_breath_q.breath_mod_enable   = breath_ff[aux_ctrl_pkg::MOD_BIT];
    nxt_breath_q.breath_phase        = breath_ff[aux_ctrl_pkg::PHASE_LSB +: 3];
    nxt_breath_q.breath_mode         = mode;
    nxt_breath_q.phase_active = (mode == aux_ctrl_pkg::MODE_EXT || mode == aux_ctrl_pkg::MODE_INT)
                                && (freq < aux_ctrl_pkg::FREQ_SQ_MIN)
                                && (nxt_breath_q.breath_phase != aux_ctrl_pkg::PHASE_BAD);
    nxt_cfg4_q.freq                     = freq;
    nxt_cfg4_q.single_shot              = cfg4_ff[aux_ctrl_pkg::SHOT_BIT];
    nxt_cfg4_q.terminal_to_drive_link   = cfg4_ff[aux_ctrl_pkg::TERM_BIT];
    nxt_cfg4_q.detach_comparator_enable = cfg4_ff[aux_ctrl_pkg::COMP_BIT];
  end

  // ---------------------------------------------------------------
  // State registers
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_i)
  begin
    if (!nrst_i)
    begin
      // All pins come up as inputs so nothing fights an external driver
      pin_dir_field_ff <= aux_ctrl_pkg::RST_PORT[aux_ctrl_pkg::PIN_DIR_LSB +: 4];
      pin_data_out_ff  <= aux_ctrl_pkg::RST_PORT[aux_ctrl_pkg::PIN_DATA_LSB +: 4];
      tap_ff           <= aux_ctrl_pkg::RST_TAP;
      breath_ff        <= aux_ctrl_pkg::RST_BRTH;
      cfg4_ff          <= aux_ctrl_pkg::RST_CFG4;
      rdata_ff         <= 32'h00000000;
      ready_ff         <= 1'b0;
      err_ff           <= 1'b0;
    end
    else
    begin
      pin_dir_field_ff <= nxt_pin_dir;
      pin_data_out_ff  <= nxt_pin_data;
      tap_ff           <= nxt_tap;
      breath_ff        <= nxt_breath;
      cfg4_ff          <= nxt_cfg4;
      rdata_ff         <= nxt_rdata;
      ready_ff         <= nxt_ready;
      err_ff           <= nxt_err;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!nrst_i)
    begin
      // Pads stay released while reset is low
      pin_out_ff <= 4'h0;
      pin_oe_ff  <= 4'h0;
    end
    else
    begin
      pin_out_ff <= nxt_pin_out;
      pin_oe_ff  <= nxt_pin_oe;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!nrst_i)
    begin
      // Decoded copies keep every output on a flop
      first_tap_ff  <= 8'h00;
      second_tap_ff <= 8'h00;
      tap_q_ff      <= '0;
      breath_q_ff   <= '0;
      cfg4_q_ff     <= '0;
    end
    else
    begin
      first_tap_ff  <= nxt_first_tap;
      second_tap_ff <= nxt_second_tap;
      tap_q_ff      <= nxt_tap_q;
      breath_q_ff   <= nxt_breath_q;
      cfg4_q_ff     <= nxt_cfg4_q;
    end
  end

  assign prdata_o            = rdata_ff;
  assign pready_o            = ready_ff;
  assign pslverr_o           = err_ff;
  assign port_pin_o          = pin_out_ff;
  assign port_pin_oe_o       = pin_oe_ff;
  assign first_tap_output_o  = first_tap_ff;
  assign second_tap_output_o = second_tap_ff;
  assign tap_o               = tap_q_ff;
  assign breath_o            = breath_q_ff;
  assign cfg4_o              = cfg4_q_ff;

endmodule
`default_nettype wire

/* testbench/aux_ctrl_props.sv */
// Purpose: Port checks for the auxiliary control register bank
// Assumes: One clock, synchronous active-low reset
// Notes: Pin checks allow one cycle of decode lag, the square wave check two
`timescale 1ns/100ps
`default_nettype none
module aux_ctrl_props
(
  input wire logic                  sys_clk_i,
  input wire logic                  nrst_i,
  input wire logic                  psel_i,
  input wire logic                  penable_i,
  input wire logic [11:0]           paddr_i,
  input wire logic [31:0]           prdata_o,
  input wire logic                  pready_o,
  input wire logic                  pslverr_o,
  input wire logic [3:0]            port_pin_o,
  input wire logic [3:0]            port_pin_oe_o,
  input wire logic [7:0]            first_tap_output_o,
  input wire logic [7:0]            second_tap_output_o,
  input wire aux_ctrl_pkg::breath_t breath_o,
  input wire aux_ctrl_pkg::cfg4_t   cfg4_o
);
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  logic ph_ok;
  assign ph_ok = (breath_o.breath_mode == 2'h1 || breath_o.breath_mode == 2'h2)
                 && cfg4_o.freq < 3'h2 && breath_o.breath_phase != 3'h7;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  sequence seq_taken;
    psel_i && penable_i && !pready_o;
  endsequence
  sequence seq_unmapped;
    seq_taken ##0 (paddr_i[11:2] < 10'h014 || paddr_i[11:2] > 10'h017);
  endsequence
  AST_ANSWER: assert property (seq_taken |=> pready_o) else $error("no answer");
  AST_PULSE: assert property (pready_o |=> !pready_o) else $error("ready too long");
  AST_ERR_READY: assert property (pslverr_o |-> pready_o) else $error("error without ready");
  AST_UNMAPPED: assert property (seq_unmapped |=> pslverr_o) else $error("no error on unmapped");
  AST_UPPER: assert property (pready_o |-> prdata_o[31:8] == 24'h000000) else $error("upper data set");
  AST_FIRST_TAP: assert property ($past(nrst_i) |-> $onehot(first_tap_output_o) &&
    (first_tap_output_o & 8'h55) == 8'h00) else $error("first tap not an even channel");
  AST_SECOND_TAP: assert property ($past(nrst_i) |-> $onehot(second_tap_output_o) &&
    (second_tap_output_o & 8'hAA) == 8'h00) else $error("second tap not an odd channel");
  AST_TAKEN: assert property ((breath_o.breath_mode[0] && cfg4_o.freq < 3'h2) [*2]
    |-> port_pin_oe_o[3:1] == 3'h0) else $error("taken pins still driven");
  AST_SQUARE: assert property ((cfg4_o.freq >= 3'h2) [*3]
    |-> port_pin_oe_o[3:2] == 2'h3 && port_pin_o[3] != port_pin_o[2]) else $error("square bad");
  AST_PHASE: assert property (breath_o.phase_active |-> ph_ok || $past(ph_ok))
    else $error("phase active out of mode");
endmodule
bind aux_ctrl_regs aux_ctrl_props u_aux_ctrl_props (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
  .psel_i(psel_i), .penable_i(penable_i), .paddr_i(paddr_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .port_pin_o(port_pin_o),
  .port_pin_oe_o(port_pin_oe_o), .first_tap_output_o(first_tap_output_o),
  .second_tap_output_o(second_tap_output_o), .breath_o(breath_o), .cfg4_o(cfg4_o));
`default_nettype wire

/* testbench/pad_model.sv */
// Purpose: Pads of the four port pins
// Assumes: Undriven pads follow an external source
// Notes: No pulls; the bench sets every external level
`timescale 1ns/100ps
`default_nettype none
module pad_model
(
  input  wire logic [3:0] oe_i,
  input  wire logic [3:0] drv_i,
  input  wire logic [3:0] ext_i,
  output logic      [3:0] lvl_o
);
  // ----------------------------------------
  // Wire resolution
  // ----------------------------------------
  always_comb
  begin
    for (int i = 0; i < 4; i++)
      lvl_o[i] = oe_i[i] ? drv_i[i] : ext_i[i];
  end
endmodule
`default_nettype wire

/* testbench/aux_ctrl_regs_bench.sv */
// Purpose: Self-checking bench for aux_ctrl_regs
// Assumes: APB master, two-cycle pin sync latency
// Notes: Square wave timed at full rate
`timescale 1ns/100ps
`default_nettype none
module aux_ctrl_regs_bench;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  logic sys_clk_i, nrst_i, psel_i, penable_i, pwrite_i, pslverr_o, pready_o, er;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, rd;
  logic [3:0] pstrb_i, pin_lvl, ext, port_pin_o, port_pin_oe_o;
  logic [7:0] first_tap_output_o, second_tap_output_o;
  aux_ctrl_pkg::tap_t tap_o;
  aux_ctrl_pkg::breath_t breath_o;
  aux_ctrl_pkg::cfg4_t cfg4_o;
  int err_total, comparisons, cyc;
  aux_ctrl_regs u_aux_ctrl_regs (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .port_pin_i(pin_lvl), .port_pin_o(port_pin_o), .port_pin_oe_o(port_pin_oe_o), .tap_o(tap_o),
    .first_tap_output_o(first_tap_output_o), .second_tap_output_o(second_tap_output_o),
    .breath_o(breath_o), .cfg4_o(cfg4_o));
  pad_model u_pad_model (.oe_i(port_pin_oe_o), .drv_i(port_pin_o), .ext_i(ext), .lvl_o(pin_lvl));
  initial
  begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task print_verdict();
    $display("err_total=%0d comparisons=%0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Request holds until pready is seen high at a rising edge; data is taken there
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge sys_clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    pstrb_i <= s;
    @(posedge sys_clk_i);
    penable_i <= 1'b1;
    do @(posedge sys_clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
  endtask
  task wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h000000, d}, 4'hF);
  endtask
  task rdc(input logic [11:0] a, input logic [7:0] exp);
    apb(1'b0, a, 32'h00000000, 4'h0);
    chk(rd, {24'h000000, exp});
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_reset();
    rdc(12'h050, 8'h0F);
    rdc(12'h054, 8'h00);
    rdc(12'h058, 8'h00);
    rdc(12'h05C, 8'h00);
    chk(first_tap_output_o, 8'h02);
  endtask
  task t_port();
    ext <= 4'h5;
    wr(12'h050, 8'hA0);
    chk(port_pin_oe_o, 4'hF);
    rdc(12'h050, 8'hA0);
    wr(12'h050, 8'h03);
    rdc(12'h050, 8'h13);
    wr(12'h050, 8'hF3);
    rdc(12'h050, 8'hD3);
    apb(1'b0, 12'h040, 32'h00000000, 4'h0);
    chk(rd, 32'h00000000);
    chk({31'h00000000, er}, 32'h00000001);
    apb(1'b1, 12'h054, 32'h0000001F, 4'h0);
    rdc(12'h054, 8'h00);
  endtask
  task t_tap();
    for (int i = 0; i < 4; i++)
    begin
      wr(12'h054, 8'hE1 | 8'(i << 3) | 8'(i << 1));
      chk(first_tap_output_o, 8'h02 << (2 * i));
      chk(second_tap_output_o, 8'h01 << (2 * i));
      chk(tap_o.tap_buffer_on, 1'b1);
      chk(tap_o, 8'(i << 3) | 8'(i << 1) | 8'h01);
      rdc(12'h054, 8'h01 | 8'(i << 3) | 8'(i << 1));
    end
    wr(12'h054, 8'h00);
    chk(tap_o.tap_buffer_on, 1'b0);
  endtask
  task t_breath();
    wr(12'h050, 8'h00);
    wr(12'h058, 8'hCE);
    chk(breath_o, 8'hDE);
    rdc(12'h058, 8'hCE);
    wr(12'h058, 8'h1D);
    chk(breath_o, 8'h39);
    // Modulation bits left at zero, as on a variant without breathing hardware
    for (int m = 0; m < 4; m++)
    begin
      wr(12'h058, 8'(m));
      chk(breath_o, 8'(m) | ((m == 1 || m == 2) ? 8'h04 : 8'h00));
      chk(port_pin_oe_o, m[0] ? 4'h1 : 4'hF);
    end
  endtask
  task t_cfg4();
    int n;
    logic v;
    wr(12'h05C, 8'h1F);
    chk(cfg4_o, 8'h07);
    rdc(12'h05C, 8'h0E);
    wr(12'h058, 8'h02);
    wr(12'h05C, 8'h40);
    chk(breath_o.phase_active, 1'b0);
    chk({port_pin_oe_o[3:2], pin_lvl[3] ^ pin_lvl[2]}, 3'h7);
    v = pin_lvl[3];
    n = 0;
    while (pin_lvl[3] === v && n < 3200)
    begin
      @(negedge sys_clk_i);
      n++;
    end
    v = pin_lvl[3];
    n = 0;
    while (pin_lvl[3] === v && n < 3200)
    begin
      @(negedge sys_clk_i);
      n++;
    end
    chk(n, 3125);
    wr(12'h05C, 8'h00);
  endtask
  // Reset in mid-run must undo every written field
  task t_rerun();
    wr(12'h050, 8'h5A);
    wr(12'h054, 8'h1F);
    wr(12'h058, 8'hFF);
    wr(12'h05C, 8'hEE);
    rdc(12'h058, 8'hFF);
    rdc(12'h05C, 8'hEE);
    @(posedge sys_clk_i);
    nrst_i <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    rdc(12'h050, 8'h5F);
    rdc(12'h054, 8'h00);
    rdc(12'h058, 8'h00);
    rdc(12'h05C, 8'h00);
    chk(port_pin_oe_o, 4'h0);
  endtask
  // ----------------------------------------
  // Sequence and timeout
  // ----------------------------------------
  always @(posedge sys_clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      err_total++;
      print_verdict();
    end
  end
  initial
  begin
    nrst_i = 1'b0; psel_i = 1'b0; penable_i = 1'b0; pwrite_i = 1'b0; paddr_i = 12'h000;
    pwdata_i = 32'h00000000; pstrb_i = 4'h0; ext = 4'h0; cyc = 0; err_total = 0; comparisons = 0;
    repeat (10) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    t_reset();
    t_port();
    t_tap();
    t_breath();
    t_cfg4();
    t_rerun();
    print_verdict();
  end
endmodule
`default_nettype wire
